// ==== src/pad_decoder.sv ====
/*
  physical address decoder: turns a core physical address into region and
  bank selects, peripheral selects, bus width and the outgoing address pins.
  assumes addr and valid are synchronous to CLK_I; decoded outputs are registered,
  one cycle after the request; APB reaches the configuration registers.
*/
//
// Summary of operation
// (RULE1) high-speed bus window is 16 Mbytes; address bits 25:24 forced to 10
// (RULE2) lcd select low on any access to the high-speed bus window
// (RULE3) high-speed bus and lcd share one window, chosen by space select
// (RULE4) width pin low gives 16 bits; high gives 16 or 32 per wide bit
// (RULE5) graphics invert reverses data bit order in lcd window both ways
// (RULE6) sync memories: bit 25 is memory clock, 32 Mbyte halves alias
// (RULE7) region 1 windows: serial, modem, infrared, infrared 2; rest reserved
// (RULE8) region 2 windows from bus control up to touch panel one
// (RULE9) region 2 upper windows audio to gpio two; rest reserved
// (RULE10) four dram banks; banks 2 and 3 expansion on wide bus when enabled
// (RULE11) ordinary and expansion size bits pick 16 or 64 Mbits
// (RULE12) per-bank size field picks 16, 64 or 128 Mbits
// (RULE13) dram banks stack upward from zero; 16-bit banks 2, 3 use col strobes
// (RULE14) wide bus expansion dram shares rom selects 2 and 3, exclusive use
// (RULE15) 16-Mbit dram on wide bus puts bank 3 below 0x0100_0000
// (RULE16) 128-Mbit rom: bank1 top, bank0, bank3 to 0x1A00_0000, bank2 below
// (RULE17) 64-Mbit rom: bank1 0x1F00_0000, bank0 0x1E00_0000, then 3 and 2
// (RULE18) addresses from 0x2000_0000 mirror the low 512 Mbytes
// (RULE19) 0x0A00_0000 to 0x0AFF_FFFF is the lcd or high-speed window
// (RULE20) reserved ranges assert no select
`timescale 1ns/1ps
`default_nettype none
module pad_decoder
  import pad_pkg::*;
(
  // clock and reset
  input  wire logic        CLK_I,
  input  wire logic        RSTN_I,
  // apb slave
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [31:0] PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic [31:0]      PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  // strap and core request
  input  wire logic        BUS_WIDTH_PIN_I,
  input  wire logic        REQ_VALID_I,
  input  wire logic [31:0] REQ_ADDR_I,
  input  wire logic [31:0] WDATA_I,
  input  wire logic [31:0] LCD_RDATA_I,
  // decoded outputs
  output logic [3:0]       ROW_STROBE_N_O,
  output logic             UPPER_COL_STROBE_N_O,
  output logic             LOWER_COL_STROBE_N_O,
  output logic [3:0]       ROM_SELECT_N_O,
  output logic             LCD_SELECT_N_O,
  output logic             HS_BUS_SEL_O,
  output logic             SYS_IO_SEL_O,
  output logic             SYS_MEM_SEL_O,
  output logic [23:0]      PERIPH_SEL_O,
  output logic             WIDE32_O,
  output logic [25:0]      ADDR_PINS_O,
  output logic             ADDR25_MEMCLK_O,
  output logic [31:0]      LCD_WDATA_O,
  output logic [31:0]      LCD_RDATA_O
);
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [31:0] PAD_OFS_CFG    = 32'h0000_0000;
  localparam logic [31:0] PAD_OFS_RAMSZ  = 32'h0000_0004;
  localparam logic [31:0] PAD_OFS_ROMSZ  = 32'h0000_0008;
  localparam logic [31:0] PAD_OFS_STATUS = 32'h0000_000C;
  localparam logic [11:0] PAD_SZ_RST     = 12'h492; // all banks 64 Mbit

  typedef enum logic [1:0] {
    PAD_R_NONE = 2'b00, PAD_R_DRAM = 2'b01, PAD_R_ROM = 2'b10, PAD_R_OTHER = 2'b11
  } pad_region_type;

  // bit-reverse for graphics mode; an involution, so readback restores data
  function automatic logic [31:0] bit_rev(input logic [31:0] v);
    for (int i = 0; i < 32; i++) bit_rev[i] = v[31-i];
  endfunction

  function automatic logic [31:0] bank_bytes(input logic [2:0] code);
    unique case (code) // [RULE12]
      PAD_SZ16: bank_bytes = PAD_B16M;
      PAD_SZ128: bank_bytes = PAD_B128M;
      default: bank_bytes = PAD_B64M;
    endcase
  endfunction

  logic [7:0]  cfg_q, cfg_d;
  logic [11:0] ramsz_q, ramsz_d, romsz_q, romsz_d;
  logic        sync_mem_q, sync_mem_d, seen_rst_q, seen_rst_d;

  // ---------------------------------------------------------------
  // apb slave: zero wait, unmapped reads zero with error
  // ---------------------------------------------------------------
  logic apb_wr, mapped;
  assign PREADY_O = 1'b1;
  assign apb_wr   = PSEL_I & PENABLE_I & PWRITE_I;
  assign mapped   = (PADDR_I == PAD_OFS_CFG) || (PADDR_I == PAD_OFS_RAMSZ) ||
                    (PADDR_I == PAD_OFS_ROMSZ) || (PADDR_I == PAD_OFS_STATUS);
  assign PSLVERR_O = PSEL_I & PENABLE_I & ~mapped;

  always_comb begin
    PRDATA_O = 32'h0000_0000;
    unique case (PADDR_I)
      PAD_OFS_CFG:    PRDATA_O = {24'h00_0000, cfg_q};
      PAD_OFS_RAMSZ:  PRDATA_O = {20'h0_0000, ramsz_q};
      PAD_OFS_ROMSZ:  PRDATA_O = {20'h0_0000, romsz_q};
      PAD_OFS_STATUS: PRDATA_O = {29'h0000_0000, sync_mem_q, WIDE32_O, BUS_WIDTH_PIN_I};
      default:        PRDATA_O = 32'h0000_0000;
    endcase
  end

  // next values of configuration; sync-memory strap caught after reset, then at each cfg write
  always_comb begin
    cfg_d      = cfg_q;
    ramsz_d    = ramsz_q;
    romsz_d    = romsz_q;
    seen_rst_d = 1'b1;
    sync_mem_d = seen_rst_q ? sync_mem_q : cfg_q[PAD_F_SYNC_MEM];
    if (apb_wr && PADDR_I == PAD_OFS_CFG)   cfg_d   = PWDATA_I[7:0];
    if (apb_wr && PADDR_I == PAD_OFS_RAMSZ) ramsz_d = PWDATA_I[11:0];
    if (apb_wr && PADDR_I == PAD_OFS_ROMSZ) romsz_d = PWDATA_I[11:0];
    // sync mode latches at each cfg write, as if caught at reset [RULE6]
    if (apb_wr && PADDR_I == PAD_OFS_CFG) sync_mem_d = PWDATA_I[PAD_F_SYNC_MEM];
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      cfg_q      <= PAD_CFG_RST;
      ramsz_q    <= PAD_SZ_RST;
      romsz_q    <= PAD_SZ_RST;
      sync_mem_q <= 1'b0;
      seen_rst_q <= 1'b0;
    end else begin
      cfg_q      <= cfg_d;
      ramsz_q    <= ramsz_d;
      romsz_q    <= romsz_d;
      sync_mem_q <= sync_mem_d;
      seen_rst_q <= seen_rst_d;
    end
  end

  // ---------------------------------------------------------------
  // bus width and bank sizes
  // ---------------------------------------------------------------
  logic        wide, exp_on;
  logic [31:0] ram_sz [4];
  logic [31:0] rom_sz [4];
  assign wide   = BUS_WIDTH_PIN_I & cfg_q[PAD_F_WIDE_PORT];               // [RULE4]
  assign exp_on = BUS_WIDTH_PIN_I & cfg_q[PAD_F_EXP_EN];                  // [RULE10]

  // size bits pick 16/64 per space unless per-bank fields are in use
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      logic xs;
      xs = BUS_WIDTH_PIN_I && (b >= 2);
      if (cfg_q[PAD_F_USE_SIZE]) begin
        ram_sz[b] = bank_bytes(ramsz_q[3*b +: 3]);                        // [RULE12]
        rom_sz[b] = bank_bytes(romsz_q[3*b +: 3]);
      end else begin
        ram_sz[b] = (xs ? cfg_q[PAD_F_XRAM64] : cfg_q[PAD_F_ORAM64]) ?
                    PAD_B64M : PAD_B16M;                                  // [RULE11]
        rom_sz[b] = PAD_B64M;
      end
      // a wide bus pairs two devices per bank, so each bank spans twice the bytes
      if (BUS_WIDTH_PIN_I) begin                                          // [RULE15] [RULE17]
        ram_sz[b] = {ram_sz[b][30:0], 1'b0};
        rom_sz[b] = {rom_sz[b][30:0], 1'b0};
      end
    end
  end

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  logic [31:0]    a;
  pad_periph_type psel;
  pad_region_type region;
  logic [3:0]     ram_hit, rom_hit;
  logic           lcd_win, sio, smem;
  assign a = REQ_ADDR_I & PAD_MIRROR_MASK;                                // [RULE18]

  pad_periph_dec u_periph (
    .addr_i (a),
    .sel_o  (psel)
  );

  assign lcd_win = a[31:24] == PAD_LCD_BASE[31:24];                       // [RULE19]
  assign sio     = (a >= PAD_SIO_BASE) && (a < PAD_ROM_BASE);
  assign smem    = (a >= PAD_SMEM_BASE) && (a < PAD_SIO_BASE);

  // dram banks stack from zero, bank 0 lowest [RULE13] [RULE15]
  always_comb begin
    logic [31:0] lo;
    logic [31:0] hi;
    lo = 32'h0000_0000;
    hi = 32'h0000_0000;
    ram_hit = 4'h0;
    for (int b = 0; b < 4; b++) begin
      hi = lo + ram_sz[b];
      if (a < PAD_DRAM_TOP && a >= lo && a < hi) ram_hit[b] = 1'b1;
      lo = hi;
    end
  end

  // rom banks stack downward from the top; wide bus order 1,0,3,2 [RULE16] [RULE17]
  always_comb begin
    logic [31:0] top;
    logic [31:0] bot;
    int          k;
    int          bk;
    top = PAD_ROM_TOP;
    bot = 32'h0000_0000;
    k   = 0;
    bk  = 0;
    rom_hit = 4'h0;
    for (k = 0; k < 4; k++) begin
      bk  = BUS_WIDTH_PIN_I ? ((k < 2) ? 1 - k : 3 - (k - 2)) : 3 - k;
      bot = top - rom_sz[bk] + 32'h0000_0001;
      if (a >= PAD_ROM_BASE && a >= bot && a <= top) rom_hit[bk] = 1'b1;
      top = bot - 32'h0000_0001;
    end
  end

  // wide-bus expansion banks belong to dram or rom, never both [RULE14]
  logic [3:0] ram_use, rom_use;
  always_comb begin
    ram_use = ram_hit;
    rom_use = rom_hit;
    if (BUS_WIDTH_PIN_I) begin
      ram_use[3:2] = exp_on ? ram_hit[3:2] : 2'b00;                       // [RULE10]
      rom_use[3:2] = exp_on ? 2'b00 : rom_hit[3:2];
    end
  end

  // ---------------------------------------------------------------
  // registered outputs
  // ---------------------------------------------------------------
  logic [3:0]  row_n_d, rom_n_d;
  logic        ucas_n_d, lcas_n_d, lcd_n_d, hs_d, sio_d, smem_d, wide_d;
  logic [23:0] per_d;
  logic [25:0] pins_d;
  logic [31:0] lwd_d, lrd_d;

  always_comb begin
    row_n_d  = 4'hF;
    rom_n_d  = 4'hF;
    ucas_n_d = 1'b1;
    lcas_n_d = 1'b1;
    lcd_n_d  = 1'b1;
    hs_d     = 1'b0;
    sio_d    = 1'b0;
    smem_d   = 1'b0;
    per_d    = 24'h00_0000;
    pins_d   = a[25:0];
    wide_d   = 1'b0;
    lwd_d    = WDATA_I;
    lrd_d    = LCD_RDATA_I;
    if (REQ_VALID_I) begin
      row_n_d[1:0] = ~ram_use[1:0];
      if (BUS_WIDTH_PIN_I) begin
        rom_n_d = ~(rom_use | ram_use & 4'hC);                           // [RULE14]
      end else begin
        rom_n_d  = ~rom_use;
        ucas_n_d = ~ram_use[3];                                          // [RULE13]
        lcas_n_d = ~ram_use[2];
        row_n_d[3:2] = ~ram_use[3:2];
      end
      if (lcd_win) begin
        wide_d = wide;                                                   // [RULE4]
        lcd_n_d = 1'b0;                                                  // [RULE2]
        hs_d = cfg_q[PAD_F_SPACE_SEL];                                   // [RULE3]
        if (cfg_q[PAD_F_SPACE_SEL]) begin
          pins_d[25:24] = PAD_HS_ADDR_HI;                                // [RULE1]
        end else if (cfg_q[PAD_F_GINVERT]) begin
          lwd_d = bit_rev(WDATA_I);                                      // [RULE5]
          lrd_d = bit_rev(LCD_RDATA_I);
        end
      end
      if (sio || smem) begin
        wide_d = wide;
        sio_d  = sio;
        smem_d = smem;
        if (sync_mem_q) pins_d[25] = 1'b0;                               // [RULE6]
      end
      if (psel != PAD_P_NONE) per_d[5'(psel - PAD_P_SER)] = 1'b1;         // [RULE20]
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ROW_STROBE_N_O       <= 4'hF;
      ROM_SELECT_N_O       <= 4'hF;
      UPPER_COL_STROBE_N_O <= 1'b1;
      LOWER_COL_STROBE_N_O <= 1'b1;
      LCD_SELECT_N_O       <= 1'b1;
      HS_BUS_SEL_O         <= 1'b0;
      SYS_IO_SEL_O         <= 1'b0;
      SYS_MEM_SEL_O        <= 1'b0;
      PERIPH_SEL_O         <= 24'h00_0000;
      WIDE32_O             <= 1'b0;
      ADDR_PINS_O          <= 26'h000_0000;
      LCD_WDATA_O          <= 32'h0000_0000;
      LCD_RDATA_O          <= 32'h0000_0000;
    end else begin
      ROW_STROBE_N_O       <= row_n_d;
      ROM_SELECT_N_O       <= rom_n_d;
      UPPER_COL_STROBE_N_O <= ucas_n_d;
      LOWER_COL_STROBE_N_O <= lcas_n_d;
      LCD_SELECT_N_O       <= lcd_n_d;
      HS_BUS_SEL_O         <= hs_d;
      SYS_IO_SEL_O         <= sio_d;
      SYS_MEM_SEL_O        <= smem_d;
      PERIPH_SEL_O         <= per_d;
      WIDE32_O             <= wide_d;
      ADDR_PINS_O          <= pins_d;
      LCD_WDATA_O          <= lwd_d;
      LCD_RDATA_O          <= lrd_d;
    end
  end

  // memory clock on bit 25 in sync mode: clock divided by two [RULE6]
  logic mclk_q, mclk_d;
  assign mclk_d = sync_mem_q ? ~mclk_q : 1'b0;
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) mclk_q <= 1'b0;
    else         mclk_q <= mclk_d;
  end
  assign ADDR25_MEMCLK_O = sync_mem_q ? mclk_q : ADDR_PINS_O[25];

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_hs_req;
    REQ_VALID_I && lcd_win && cfg_q[PAD_F_SPACE_SEL];
  endsequence
  a_hs_addr_pins: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    s_hs_req |=> ADDR_PINS_O[25:24] == 2'b10) else $error("hs address bits wrong"); // [RULE1]
  a_lcd_select: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    REQ_VALID_I && lcd_win |=> !LCD_SELECT_N_O) else $error("lcd select missing"); // [RULE2]
  a_space_excl: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    HS_BUS_SEL_O |-> $past(cfg_q[PAD_F_SPACE_SEL])) else $error("hs without select"); // [RULE3]
  a_narrow_width: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    !BUS_WIDTH_PIN_I |=> !WIDE32_O) else $error("wide on narrow pin"); // [RULE4]
  a_invert_data: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    REQ_VALID_I && lcd_win && !cfg_q[PAD_F_SPACE_SEL] && cfg_q[PAD_F_GINVERT]
    |=> LCD_WDATA_O == bit_rev($past(WDATA_I))) else $error("no inversion"); // [RULE5]
  a_mirror_map: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    a[31:29] == 3'h0) else $error("mirror fold broken"); // [RULE18]
  a_rom_onehot: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    $countones(~ROM_SELECT_N_O) <= 1) else $error("two rom selects"); // [RULE14]
  a_reserved_quiet: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    REQ_VALID_I && a >= PAD_IO1_BASE && a > PAD_IO1_LAST && a < PAD_SMEM_BASE
    |=> PERIPH_SEL_O == 24'h00_0000) else $error("reserved selected"); // [RULE20]
  a_bank0_low: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    REQ_VALID_I && a < PAD_B16M |=> !ROW_STROBE_N_O[0]) else $error("bank0 not at zero"); // [RULE13]
  a_io1_serial: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    REQ_VALID_I && a[31:5] == PAD_IO1_BASE[31:5] |=> PERIPH_SEL_O[0]) else $error("serial"); // [RULE7]
endmodule
`default_nettype wire

// ==== src/pad_periph_dec.sv ====
/*
  decoder of the 32-byte internal i/o windows of regions 1 and 2.
  assumes the address is already folded into the low 512 Mbytes.
*/
`timescale 1ns/1ps
`default_nettype none
module pad_periph_dec
  import pad_pkg::*;
(
  // address in
  input  wire logic [31:0]   addr_i,
  // decoded peripheral
  output pad_periph_type     sel_o
);
  logic [9:0] win;
  assign win = addr_i[14:5];

  // ---------------------------------------------------------------
  // window lookup; reserved windows give none
  // ---------------------------------------------------------------
  always_comb begin
    sel_o = PAD_P_NONE;
    if ((addr_i >= PAD_IO1_BASE) && (addr_i <= PAD_IO1_LAST)) begin // [RULE7]
      unique case (addr_i[6:5])
        2'h0: sel_o = PAD_P_SER;
        2'h1: sel_o = PAD_P_MODEM;
        2'h2: sel_o = PAD_P_IR;
        2'h3: sel_o = PAD_P_IR2;
      endcase
    end else if ((addr_i >= PAD_IO2_BASE) && (addr_i < PAD_IO2_END)) begin
      case (win) // [RULE8] [RULE9]
        10'h000: sel_o = PAD_P_BUSC;
        10'h001: sel_o = PAD_P_DMA_ADDRESS_UNIT;
        10'h002: sel_o = PAD_P_DMAC;
        10'h003: sel_o = PAD_P_CLKM;
        10'h004: sel_o = PAD_P_IRQ1;
        10'h005: sel_o = PAD_P_PWR;
        10'h006: sel_o = PAD_P_RTC_ONE;
        10'h007: sel_o = PAD_P_DEAD;
        10'h008: sel_o = PAD_P_GPIO1;
        10'h009: sel_o = PAD_P_TP1;
        10'h00B: sel_o = PAD_P_AUD;
        10'h00C: sel_o = PAD_P_KEY;
        10'h00D: sel_o = PAD_P_DBG;
        10'h00E: sel_o = PAD_P_RTC_TWO;
        10'h010: sel_o = PAD_P_IRQ2;
        10'h012: sel_o = PAD_P_LED;
        10'h015: sel_o = PAD_P_TP2;
        10'h016: sel_o = PAD_P_PWR2;
        10'h017: sel_o = PAD_P_GPIO2;
        default: sel_o = PAD_P_NONE; // reserved holes [RULE20]
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== src/pad_pkg.sv ====
/*
  package for the physical address decoder: region bases, window offsets,
  field positions of the configuration word, size codes and reset values.
  assumes a 32-bit physical address from the core.
*/
package pad_pkg;
  // ---------------------------------------------------------------------
  // region map (upper address bits)
  // ---------------------------------------------------------------------
  localparam logic [31:0] PAD_MIRROR_MASK = 32'h1FFF_FFFF;
  localparam logic [31:0] PAD_ROM_BASE    = 32'h1800_0000;
  localparam logic [31:0] PAD_ROM_TOP     = 32'h1FFF_FFFF;
  localparam logic [31:0] PAD_SIO_BASE    = 32'h1400_0000;
  localparam logic [31:0] PAD_SMEM_BASE   = 32'h1000_0000;
  localparam logic [31:0] PAD_IO1_BASE    = 32'h0C00_0000;
  localparam logic [31:0] PAD_IO1_LAST    = 32'h0C00_007F;
  localparam logic [31:0] PAD_IO2_BASE    = 32'h0B00_0000;
  localparam logic [31:0] PAD_IO2_END     = 32'h0B00_0300;
  localparam logic [31:0] PAD_LCD_BASE    = 32'h0A00_0000;
  localparam logic [31:0] PAD_DRAM_TOP    = 32'h0800_0000;
  localparam logic [31:0] PAD_MB16        = 32'h0100_0000;
  localparam logic [31:0] PAD_SBUS_ALIAS  = 32'h01FF_FFFF; // low 32 Mbytes
  localparam logic [1:0]  PAD_HS_ADDR_HI  = 2'h2;          // address bits 25:24
  localparam int          PAD_WIN_SHIFT   = 5;             // 32-byte windows
  // ---------------------------------------------------------------------
  // bank size codes (per-bank field, 3 bits)
  // ---------------------------------------------------------------------
  localparam logic [2:0] PAD_SZ16  = 3'h0;
  localparam logic [2:0] PAD_SZ64  = 3'h2;
  localparam logic [2:0] PAD_SZ128 = 3'h4;
  localparam logic [31:0] PAD_B16M  = 32'h0020_0000; // 16 Mbit = 2 Mbyte
  localparam logic [31:0] PAD_B64M  = 32'h0080_0000;
  localparam logic [31:0] PAD_B128M = 32'h0100_0000;
  // ---------------------------------------------------------------------
  // configuration word fields
  // ---------------------------------------------------------------------
  localparam int PAD_F_SPACE_SEL  = 0;
  localparam int PAD_F_WIDE_PORT  = 1;
  localparam int PAD_F_GINVERT    = 2;
  localparam int PAD_F_EXP_EN     = 3;
  localparam int PAD_F_USE_SIZE   = 4;  // take per-bank sizes, not 16/64 bits
  localparam int PAD_F_ORAM64     = 5;
  localparam int PAD_F_XRAM64     = 6;
  localparam int PAD_F_SYNC_MEM   = 7;  // sync dram and sync rom fitted
  localparam logic [7:0] PAD_CFG_RST = 8'h00;
  // ---------------------------------------------------------------------
  // peripheral select index (one-hot bit number plus one)
  // ---------------------------------------------------------------------
  typedef enum logic [4:0] {
    PAD_P_NONE = 5'h00, PAD_P_SER = 5'h01, PAD_P_MODEM = 5'h02,
    PAD_P_IR = 5'h03, PAD_P_IR2 = 5'h04, PAD_P_BUSC = 5'h05,
    PAD_P_DMA_ADDRESS_UNIT = 5'h06, PAD_P_DMAC = 5'h07, PAD_P_CLKM = 5'h08,
    PAD_P_IRQ1 = 5'h09, PAD_P_PWR = 5'h0A, PAD_P_RTC_ONE = 5'h0B,
    PAD_P_DEAD = 5'h0C, PAD_P_GPIO1 = 5'h0D, PAD_P_TP1 = 5'h0E,
    PAD_P_AUD = 5'h0F, PAD_P_KEY = 5'h10, PAD_P_DBG = 5'h11,
    PAD_P_RTC_TWO = 5'h12, PAD_P_IRQ2 = 5'h13, PAD_P_LED = 5'h14,
    PAD_P_TP2 = 5'h15, PAD_P_PWR2 = 5'h16, PAD_P_GPIO2 = 5'h17
  } pad_periph_type;
  localparam int PAD_NPERIPH = 24;
endpackage

// ==== verif/pad_lcd_model.sv ====
/*
  lcd controller model on the far side of the decoder's lcd window.
  assumes select and write data are registered decoder outputs.
*/
`timescale 1ns/1ps
`default_nettype none
module pad_lcd_model (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // decoder side
  input  wire logic        lcd_select_n_i,
  input  wire logic [31:0] wdata_i,
  output logic [31:0]      rdata_o
);
  logic [31:0] mem_q;
  // a selected cycle stores the bus word, so readback shows what was written
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) mem_q <= 32'h0000_0000;
    else if (!lcd_select_n_i) mem_q <= wdata_i;
  end
  // released bus shows the inverse, never a stale copy
  assign rdata_o = lcd_select_n_i ? ~mem_q : mem_q;
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
/*
  self-checking bench of the address decoder: apb set-up, core requests.
  assumes registered decoder outputs one cycle after each request.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import pad_pkg::*;
  // ---------------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------------
  logic        clk, rstn, psel, pen, pwr, pin, vld, pready, perr, er;
  logic        lcd_n, hs, wide, ucs;
  logic [31:0] paddr, pwd, addr, wd, lrd, prd, lwd, lrdo, rd;
  logic [3:0]  ras_n, rom_n;
  logic [23:0] psel_o;
  logic [25:0] apins;
  logic [11:0] hi_off [9] = '{12'h160, 12'h180, 12'h1A0, 12'h1C0, 12'h200,
                              12'h240, 12'h2A0, 12'h2C0, 12'h2E0};
  logic [31:0] rsv [6] = '{32'h0C00_0080, 32'h0B00_0140, 32'h0B00_01E0,
                           32'h0B00_0220, 32'h0B00_0260, 32'h0B00_0300};
  logic [31:0] a, d;
  int          errors, check_count, seed, k;
  pad_decoder i_dut (.CLK_I(clk), .RSTN_I(rstn), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwd), .PRDATA_O(prd),
    .PREADY_O(pready), .PSLVERR_O(perr), .BUS_WIDTH_PIN_I(pin), .REQ_VALID_I(vld),
    .REQ_ADDR_I(addr), .WDATA_I(wd), .LCD_RDATA_I(lrd), .ROW_STROBE_N_O(ras_n),
    .UPPER_COL_STROBE_N_O(ucs), .LOWER_COL_STROBE_N_O(), .ROM_SELECT_N_O(rom_n),
    .LCD_SELECT_N_O(lcd_n), .HS_BUS_SEL_O(hs), .SYS_IO_SEL_O(), .SYS_MEM_SEL_O(),
    .PERIPH_SEL_O(psel_o), .WIDE32_O(wide), .ADDR_PINS_O(apins),
    .ADDR25_MEMCLK_O(), .LCD_WDATA_O(lwd), .LCD_RDATA_O(lrdo));
  pad_lcd_model i_lcd (.clk_i(clk), .rstn_i(rstn), .lcd_select_n_i(lcd_n),
    .wdata_i(lwd), .rdata_o(lrd));
  // ---------------------------------------------------------------------
  // tasks and expectation helpers
  // ---------------------------------------------------------------------
  function automatic logic [31:0] rev(input logic [31:0] v);
    rev = {<<{v}};
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  // apb transfer held until pready is sampled high at a rising edge
  task automatic apb(input logic w, input logic [31:0] ad, input logic [31:0] dt);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1; pwr <= w; paddr <= ad; pwd <= dt;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) errors++;
    rd = prd;
    er = perr;
    psel <= 1'b0; pen <= 1'b0;
  endtask
  // one core request; outputs settle one edge later
  task automatic req(input logic [31:0] ad, input logic [31:0] dt);
    @(posedge clk);
    vld <= 1'b1; addr <= ad; wd <= dt;
    @(posedge clk);
    #1;
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ---------------------------------------------------------------------
  // clock, watchdog, main sequence
  // ---------------------------------------------------------------------
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #200000;
    errors++;
    conclude();
  end
  initial begin
    seed = 32'hbbe3_72ab;
    {rstn, psel, pen, pwr, pin, vld} = '0;
    {paddr, pwd, addr, wd} = '0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    #1;
    chk("idle selects", 32'h0001_FF00, {lcd_n, rom_n, ras_n, 3'h0, psel_o[4:0]});
    apb(1'b0, 32'h0000_0004, 32'h0);
    chk("ram size reset", 32'h0000_0492, rd);
    apb(1'b0, 32'h0000_0010, 32'h0);
    chk("unmapped", 32'h0000_0000, rd | {31'h0, ~er});
    for (k = 0; k < 23; k++) begin
      a = (k < 4) ? 32'h0C00_0000 + k * 32 : (k < 14) ? 32'h0B00_0000 + (k - 4) * 32
        : 32'h0B00_0000 + hi_off[k-14];
      a[31:29] = $random(seed);
      req(a | ($random(seed) & 31), $random(seed));
      chk("periph", 32'h1 << k, {8'h0, psel_o});
    end
    for (k = 0; k < 6; k++) begin
      req(rsv[k], 32'h0);
      chk("reserved", 32'h0001_FF00, {lcd_n, rom_n, ras_n, psel_o[7:0]});
    end
    for (k = 0; k < 4; k++) begin
      pin <= k[1];
      apb(1'b1, 32'h0000_0000, {30'h0, k[0], 1'b1});
      req(32'h0A00_0000 | ($random(seed) & 32'h00FF_FFFF), 32'h0);
      chk("hs window", 32'h0000_0006, {lcd_n, hs, apins[25:24]});
      chk("width", {31'h0, k[1] & k[0]}, {31'h0, wide});
    end
    apb(1'b1, 32'h0000_0000, 32'h0000_0004);
    d = $random(seed);
    req(32'h0A00_0100, d);
    chk("lcd select", 32'h0, {31'h0, lcd_n | hs});
    chk("invert write", rev(d), lwd);
    req(32'h0A00_0100, d);
    req(32'h0A00_0100, d);
    chk("invert read", d, lrdo);
    pin <= 1'b0;
    apb(1'b1, 32'h0000_0000, 32'h0000_0000);
    req(32'h0000_0010, 32'h0);
    chk("dram bank0", 32'hE, {28'h0, ras_n});
    req(32'h0020_0000, 32'h0);
    chk("dram bank1", 32'hD, {28'h0, ras_n});
    req(32'h0060_0000, 32'h0);
    chk("dram bank3", 32'h0, {31'h0, ucs});
    pin <= 1'b1;
    apb(1'b1, 32'h0000_0000, 32'h0000_0008);
    req(32'h00FF_FFF0, 32'h0);
    chk("exp dram", 32'h7, {28'h0, rom_n});
    req(32'h1F00_0000, 32'h0);
    chk("rom bank1", 32'hD, {28'h0, rom_n});
    req(32'h1E00_0000, 32'h0);
    chk("rom bank0", 32'hE, {28'h0, rom_n});
    apb(1'b1, 32'h0000_0008, 32'h0000_0924);
    apb(1'b1, 32'h0000_0000, 32'h0000_0010);
    req(32'h1A00_0000, 32'h0);
    chk("rom128 bank3", 32'h7, {28'h0, rom_n});
    req(32'h1800_0000, 32'h0);
    chk("rom128 bank2", 32'hB, {28'h0, rom_n});
    conclude();
  end
endmodule
`default_nettype wire
